//--- pkg/mpr_pkg.sv
// constants and types of the missing-page report responder
// assumes one 125 MHz clock, APB register access, byte-wide message streams
//
// What this block does
// - version and reserved fields are zero
// - receiving state answers bitmap or list report
// - other states answer with upgrade-state reply
// - bitmap report: type 8, count, page number
// - bitmap page number is start or later
// - nothing missing after start: search from zero
// - first bitmap byte msb is first page
// - bit one means missing, zero received
// - bitmap may wrap to page zero
// - report body never exceeds page byte size
// - list report: type 9, count, 32-bit pages
// - list ascending, may wrap to zero
// - first listed page is start or later
// - device picks bitmap or list report
// - during image check answer empty report
// - state reply type 5, receiving is 1
// - page byte size 32, 64, 128 or 192
package mpr_pkg;

  localparam int APB_AW = 8;
  localparam int PAGE_AW = 12;

  // register offsets
  localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_TOTAL = 8'h04;
  localparam logic [APB_AW-1:0] OFF_CRC = 8'h08;
  localparam logic [APB_AW-1:0] OFF_RCVD = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_STAT = 8'h10;

  // control field positions
  localparam int CTRL_STATE_LSB = 0;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_SIZE_LSB = 5;
  localparam int CTRL_MODE_LSB = 7;
  localparam int CTRL_CLEAR_BIT = 9;

  // reset values
  localparam logic [3:0] STATE_RESET = 4'h0;
  localparam logic [31:0] TOTAL_RESET = 32'h0000_0000;
  localparam logic [31:0] CRC_RESET = 32'h0000_0000;

  // message codes
  localparam logic [3:0] TYPE_STATE = 4'h5;
  localparam logic [3:0] TYPE_QUERY = 4'h7;
  localparam logic [3:0] TYPE_BITMAP = 4'h8;
  localparam logic [3:0] TYPE_LIST = 4'h9;
  localparam logic [1:0] MSG_VERSION = 2'h0;
  localparam logic [1:0] MSG_RSVD = 2'h0;
  localparam logic [3:0] STATE_RECEIVING = 4'h1;

  // byte counts
  localparam logic [2:0] QUERY_LEN = 3'h5;
  localparam logic [3:0] HDR_LEN_BITMAP = 4'h9;
  localparam logic [3:0] HDR_LEN_LIST = 4'h5;
  localparam logic [3:0] HDR_LEN_STATE = 4'h6;
  // list chosen in auto mode when missing * 32 <= total
  localparam int SPARSE_SHIFT = 5;

  typedef enum logic [1:0] {
    MODE_AUTO = 2'h0,
    MODE_BITMAP = 2'h1,
    MODE_LIST = 2'h2,
    MODE_AUTO_ALT = 2'h3
  } mpr_mode_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SCAN = 3'b001,
    S_HEAD = 3'b011,
    S_BODY = 3'b010,
    S_LIST = 3'b110,
    S_DONE = 3'b111
  } mpr_state_t;

  function automatic logic [7:0] page_bytes_f(input logic [1:0] sel);
    case (sel)
      2'h0: page_bytes_f = 8'h20;
      2'h1: page_bytes_f = 8'h40;
      2'h2: page_bytes_f = 8'h80;
      default: page_bytes_f = 8'hC0;
    endcase
  endfunction

endpackage

//--- hw/mpr_page_mem.sv
// one received flag per image page
// assumes one write and one read per cycle, read data one cycle late
`timescale 1ns/1ns
module mpr_page_mem #(
  parameter int AW = 12
) (
  // clock
  input wire logic i_clock,
  // write port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic i_wr_bit,
  // read port
  input wire logic [AW-1:0] i_rd_addr,
  output logic o_rd_bit
);

  logic [(1<<AW)-1:0] mem_q;

  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_bit;
    end
    o_rd_bit <= mem_q[i_rd_addr];
  end

endmodule // mpr_page_mem

//--- hw/mpr_responder.sv
// missing-page query parser and report framer with APB registers
// assumes rx, tx and page marks come from logic on i_clock
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module mpr_responder #(
  parameter int PAGE_AW = mpr_pkg::PAGE_AW
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [mpr_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // incoming message bytes
  input wire logic i_rx_valid,
  input wire logic i_rx_first,
  input wire logic [7:0] i_rx_data,
  // page stored by the page-data logic
  input wire logic i_mark_valid,
  input wire logic [PAGE_AW-1:0] i_mark_page,
  // outgoing reply bytes
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  output logic o_tx_done
);
  import mpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [3:0] upg_state_q;
  logic crc_busy_q;
  logic [1:0] size_sel_q;
  mpr_mode_t mode_q;
  logic [31:0] total_q;
  logic [31:0] crc_q;
  logic [31:0] rcvd_q;
  logic [3:0] last_type_q;
  logic clr_act_q;
  logic [PAGE_AW-1:0] clr_cnt_q;
  mpr_state_t st_q;

  wire setup = i_psel & ~i_penable;
  wire wr_fire = i_psel & i_penable & i_pwrite & o_pready;
  wire hit_ctrl = i_paddr == OFF_CTRL;
  wire hit_total = i_paddr == OFF_TOTAL;
  wire hit_crc = i_paddr == OFF_CRC;
  wire hit_rcvd = i_paddr == OFF_RCVD;
  wire hit_stat = i_paddr == OFF_STAT;
  wire mapped = hit_ctrl | hit_total | hit_crc | hit_rcvd | hit_stat;
  wire [31:0] ctrl_rd = {22'h0, clr_act_q, mode_q, size_sel_q, crc_busy_q, upg_state_q};
  wire [31:0] stat_rd = {24'h0, 1'b0, st_q, last_type_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd : hit_total ? total_q : hit_crc ? crc_q :
                       hit_rcvd ? rcvd_q : hit_stat ? stat_rd : 32'h0000_0000;
  wire clr_start = wr_fire & hit_ctrl & i_pwdata[CTRL_CLEAR_BIT];

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup & ~mapped;
      o_prdata <= setup ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      upg_state_q <= STATE_RESET;
      crc_busy_q <= 1'b0;
      size_sel_q <= 2'h0;
      mode_q <= MODE_AUTO;
      total_q <= TOTAL_RESET;
      crc_q <= CRC_RESET;
    end else if (wr_fire) begin
      if (hit_ctrl) begin
        upg_state_q <= i_pwdata[CTRL_STATE_LSB +: 4];
        crc_busy_q <= i_pwdata[CTRL_BUSY_BIT];
        size_sel_q <= i_pwdata[CTRL_SIZE_LSB +: 2];
        mode_q <= mpr_mode_t'(i_pwdata[CTRL_MODE_LSB +: 2]);
      end
      if (hit_total) begin
        total_q <= i_pwdata;
      end
      if (hit_crc) begin
        crc_q <= i_pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page flags: sweep to zero after reset or on request

  logic rd_bit;
  wire mem_wr = clr_act_q | i_mark_valid;
  wire [PAGE_AW-1:0] mem_waddr = clr_act_q ? clr_cnt_q : i_mark_page;
  logic [31:0] p_q;

  mpr_page_mem #(.AW(PAGE_AW)) u_mem (
    .i_clock(i_clock),
    .i_wr_en(mem_wr),
    .i_wr_addr(mem_waddr),
    .i_wr_bit(~clr_act_q),
    .i_rd_addr(p_q[PAGE_AW-1:0]),
    .o_rd_bit(rd_bit)
  );

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      clr_act_q <= 1'b1;
      clr_cnt_q <= '0;
      rcvd_q <= 32'h0000_0000;
    end else if (clr_start) begin
      clr_act_q <= 1'b1;
      clr_cnt_q <= '0;
      rcvd_q <= 32'h0000_0000;
    end else if (clr_act_q) begin
      clr_cnt_q <= clr_cnt_q + 1'b1;
      clr_act_q <= ~&clr_cnt_q;
    end else if (i_mark_valid) begin
      rcvd_q <= rcvd_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // query parser

  logic [2:0] rx_cnt_q;
  logic [31:0] start_q;
  wire [7:0] query_head = {TYPE_QUERY, MSG_VERSION, MSG_RSVD};
  wire [31:0] start_d = {start_q[23:0], i_rx_data};
  wire rx_more = (rx_cnt_q != 3'h0) & (rx_cnt_q < QUERY_LEN);
  wire query_fire = i_rx_valid & ~i_rx_first & (rx_cnt_q == QUERY_LEN - 3'h1);
  wire trigger = query_fire & (st_q == S_IDLE) & ~clr_act_q;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      rx_cnt_q <= 3'h0;
      start_q <= 32'h0000_0000;
    end else if (i_rx_valid) begin
      if (i_rx_first) begin
        rx_cnt_q <= (i_rx_data == query_head) ? 3'h1 : 3'h0;
      end else if (rx_more) begin
        rx_cnt_q <= rx_cnt_q + 3'h1;
        start_q <= start_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // report framer

  logic [79:0] hdr_q;
  logic [3:0] hdr_n_q;
  logic bm_q;
  logic empty_q;
  logic rd_wait_q;
  logic [31:0] vis_q;
  logic [31:0] base_q;
  logic [10:0] units_q;
  logic [7:0] acc_q;
  logic [3:0] acc_n_q;
  logic [31:0] ent_q;
  logic [1:0] ent_n_q;
  logic lst_last_q;

  wire receiving = upg_state_q == STATE_RECEIVING;
  wire [31:0] first0 = (start_d < total_q) ? start_d : 32'h0000_0000;
  wire [31:0] p_inc = p_q + 32'h0000_0001;
  wire [31:0] p_next = (p_inc == total_q) ? 32'h0000_0000 : p_inc;
  wire vis_last = (vis_q + 32'h0000_0001) == total_q;
  wire missing = ~rd_bit;
  wire [31:0] missing_cnt = total_q - rcvd_q;
  wire sparse = {missing_cnt, 5'h00} <= {5'h00, total_q};
  wire pick_bm = (mode_q == MODE_BITMAP) | ((mode_q != MODE_LIST) & ~sparse);
  wire [7:0] pg_bytes = page_bytes_f(size_sel_q);
  wire [10:0] limit = bm_q ? {pg_bytes, 3'h0} : {5'h00, pg_bytes[7:2]};
  wire [10:0] units_inc = units_q + 11'h001;
  wire tx_free = ~o_tx_valid | i_tx_ready;
  wire step = (st_q == S_BODY) & rd_wait_q & tx_free;
  wire [7:0] acc_new = {acc_q[6:0], missing};
  wire [3:0] nb = acc_n_q + 4'h1;
  wire bm_stop = vis_last | (units_inc == limit);
  wire [7:0] bm_byte = acc_new << (4'h8 - nb);
  wire emit_bm = step & bm_q & ((nb == 4'h8) | bm_stop);
  wire emit = tx_free & ((st_q == S_HEAD) | (st_q == S_LIST)) | emit_bm;
  wire [7:0] emit_data = (st_q == S_HEAD) ? hdr_q[79:72] : (st_q == S_LIST) ? ent_q[31:24] : bm_byte;
  wire [7:0] bm_head = {TYPE_BITMAP, MSG_VERSION, MSG_RSVD};
  wire [7:0] lst_head = {TYPE_LIST, MSG_VERSION, MSG_RSVD};
  wire [7:0] st_head = {TYPE_STATE, MSG_VERSION, MSG_RSVD};
  wire [31:0] scan_pg = missing ? p_q : base_q;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      st_q <= S_IDLE;
      hdr_q <= '0;
      hdr_n_q <= 4'h0;
      bm_q <= 1'b0;
      empty_q <= 1'b0;
      rd_wait_q <= 1'b0;
      p_q <= 32'h0000_0000;
      vis_q <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
      units_q <= 11'h000;
      acc_q <= 8'h00;
      acc_n_q <= 4'h0;
      ent_q <= 32'h0000_0000;
      ent_n_q <= 2'h0;
      lst_last_q <= 1'b0;
      last_type_q <= 4'h0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (trigger) begin
            rd_wait_q <= 1'b0;
            p_q <= first0;
            base_q <= first0;
            vis_q <= 32'h0000_0000;
            units_q <= 11'h000;
            acc_n_q <= 4'h0;
            if (!receiving) begin
              hdr_q <= {st_head, upg_state_q, 4'h0, crc_q, 32'h0000_0000};
              hdr_n_q <= HDR_LEN_STATE;
              empty_q <= 1'b1;
              last_type_q <= TYPE_STATE;
              st_q <= S_HEAD;
            end else if (crc_busy_q || total_q == 32'h0000_0000) begin
              hdr_q <= {lst_head, rcvd_q, 40'h00_0000_0000};
              hdr_n_q <= HDR_LEN_LIST;
              empty_q <= 1'b1;
              last_type_q <= TYPE_LIST;
              st_q <= S_HEAD;
            end else begin
              bm_q <= pick_bm;
              empty_q <= 1'b0;
              st_q <= S_SCAN;
            end
          end
        end
        S_SCAN: begin
          rd_wait_q <= ~rd_wait_q;
          if (rd_wait_q && (missing || vis_last)) begin
            empty_q <= ~missing;
            p_q <= scan_pg;
            vis_q <= 32'h0000_0000;
            hdr_q <= bm_q ? {bm_head, rcvd_q, scan_pg, 8'h00} : {lst_head, rcvd_q, 40'h00_0000_0000};
            hdr_n_q <= bm_q ? HDR_LEN_BITMAP : HDR_LEN_LIST;
            last_type_q <= bm_q ? TYPE_BITMAP : TYPE_LIST;
            rd_wait_q <= 1'b0;
            st_q <= S_HEAD;
          end else if (rd_wait_q) begin
            p_q <= p_next;
            vis_q <= vis_q + 32'h0000_0001;
          end
        end
        S_HEAD: begin
          if (tx_free) begin
            hdr_q <= {hdr_q[71:0], 8'h00};
            hdr_n_q <= hdr_n_q - 4'h1;
            if (hdr_n_q == 4'h1) begin
              st_q <= empty_q ? S_DONE : S_BODY;
            end
          end
        end
        S_BODY: begin
          if (!rd_wait_q) begin
            rd_wait_q <= 1'b1;
          end else if (step && bm_q) begin
            acc_q <= acc_new;
            acc_n_q <= (nb == 4'h8) ? 4'h0 : nb;
            units_q <= units_inc;
            p_q <= p_next;
            vis_q <= vis_q + 32'h0000_0001;
            rd_wait_q <= 1'b0;
            if (bm_stop) begin
              st_q <= S_DONE;
            end
          end else if (step) begin
            p_q <= p_next;
            vis_q <= vis_q + 32'h0000_0001;
            rd_wait_q <= 1'b0;
            if (missing) begin
              ent_q <= p_q;
              ent_n_q <= 2'h0;
              lst_last_q <= vis_last;
              st_q <= S_LIST;
            end else if (vis_last) begin
              st_q <= S_DONE;
            end
          end
        end
        S_LIST: begin
          if (tx_free) begin
            ent_q <= {ent_q[23:0], 8'h00};
            ent_n_q <= ent_n_q + 2'h1;
            if (ent_n_q == 2'h3) begin
              units_q <= units_inc;
              st_q <= (lst_last_q || units_inc == limit) ? S_DONE : S_BODY;
            end
          end
        end
        S_DONE: begin
          if (!o_tx_valid) begin
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_done <= 1'b0;
    end else begin
      o_tx_done <= (st_q == S_DONE) & ~o_tx_valid;
      if (emit) begin
        o_tx_valid <= 1'b1;
        o_tx_data <= emit_data;
      end else if (i_tx_ready) begin
        o_tx_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  state_reply_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    trigger && !receiving |=> st_q == S_HEAD && hdr_q[79:72] == 8'h50 && hdr_n_q == 4'h6)
    else $error("state reply not framed");
  recv_scan_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    trigger && receiving && !crc_busy_q && total_q != 32'h0000_0000 |=> st_q == S_SCAN)
    else $error("receiving query did not start a scan");
  busy_empty_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    trigger && receiving && crc_busy_q |=> empty_q && hdr_q[79:72] == 8'h90 ##5 st_q == S_DONE || !tx_free)
    else $error("busy check gave a non-empty report");
  bitmap_head_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    st_q == S_HEAD && $past(st_q) == S_SCAN && hdr_n_q == HDR_LEN_BITMAP
    |-> hdr_q[79:72] == 8'h80)
    else $error("bitmap type wrong");
  head_type_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    $rose(st_q == S_HEAD) && $past(st_q) == S_SCAN |-> hdr_q[79:72] == (bm_q ? 8'h80 : 8'h90))
    else $error("report type does not match chosen kind");
  bitmap_page_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    $rose(st_q == S_HEAD) && $past(st_q) == S_SCAN && bm_q |-> hdr_q[39:8] == p_q)
    else $error("bitmap page number differs from first page");
  first_missing_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    st_q == S_SCAN && rd_wait_q && missing |=> st_q == S_HEAD && !empty_q ##0 p_q == $past(p_q))
    else $error("scan passed a missing page");
  body_limit_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    st_q == S_BODY || st_q == S_LIST |-> units_q <= limit)
    else $error("report body longer than page size");
  page_wrap_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    st_q == S_BODY && total_q != 32'h0000_0000 |-> p_q < total_q)
    else $error("page number beyond image");
  head_nibble_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    st_q == S_HEAD && $past(st_q) != S_HEAD |-> hdr_q[75:72] == 4'h0)
    else $error("version or reserved bits set");

endmodule // mpr_responder

//--- testbench/mpr_base_node.sv
// base node model: sends missing-page queries, collects reply bytes
// assumes the responder's byte streams run on i_clock
`timescale 1ns/1ns
module mpr_base_node (
  // clock and pacing
  input wire logic i_clock,
  input wire logic i_slow,
  // query bytes
  output logic o_rx_valid,
  output logic o_rx_first,
  output logic [7:0] o_rx_data,
  // reply bytes
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  import mpr_pkg::*;
  logic [7:0] reply_q[$];
  logic tog_q = 1'b0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_first = 1'b0;
    o_rx_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // sink; slow mode takes a byte every other cycle
  assign o_tx_ready = !i_slow || tog_q;
  always @(posedge i_clock) begin
    tog_q <= ~tog_q;
    if (i_tx_valid && o_tx_ready) begin
      reply_q.push_back(i_tx_data);
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic send_query(input logic [31:0] start);
    logic [39:0] msg;
    msg = {TYPE_QUERY, MSG_VERSION, MSG_RSVD, start};
    for (int i = 4; i >= 0; i--) begin
      @(posedge i_clock);
      o_rx_valid <= 1'b1;
      o_rx_first <= (i == 4);
      o_rx_data <= msg[i*8 +: 8];
    end
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    o_rx_first <= 1'b0;
    // released line: no stale byte
    o_rx_data <= ~msg[7:0];
  endtask
endmodule // mpr_base_node

//--- testbench/testbench.sv
// self-checking bench: APB tasks, page marks and queries through the base node model
// assumes a 125 MHz clock and a shortened page memory
`timescale 1ns/1ns
module testbench;
  import mpr_pkg::*;
  localparam int AW = 6;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mark_valid = 1'b0, slow = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, rx_valid, rx_first, tx_valid, tx_ready, tx_done, err;
  logic [AW-1:0] mark_page = '0;
  logic [7:0] rx_data, tx_data, exp_q[$];
  int n_mismatch = 0, n_compared = 0, cycles = 0;
  int sizes[4] = '{32, 64, 128, 192};
  initial forever #4 i_clock = ~i_clock;
  mpr_responder #(.PAGE_AW(AW)) dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rx_valid(rx_valid), .i_rx_first(rx_first),
    .i_rx_data(rx_data), .i_mark_valid(mark_valid), .i_mark_page(mark_page), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_tx_done(tx_done));
  mpr_base_node base (.i_clock(i_clock), .i_slow(slow), .o_rx_valid(rx_valid), .o_rx_first(rx_first),
    .o_rx_data(rx_data), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    // hold the request until pready is seen at a rising edge
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] e, input logic e_err);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
    check(err, e_err);
  endtask
  task automatic wait_sweep();
    rd = 32'h0000_0200;
    for (int i = 0; i < 200 && rd[CTRL_CLEAR_BIT] !== 1'b0; i++) apb(1'b0, OFF_CTRL, 32'h0000_0000);
    check(rd[CTRL_CLEAR_BIT], 1'b0);
  endtask
  task automatic mark(input int p);
    @(posedge i_clock);
    mark_valid <= 1'b1;
    mark_page <= AW'(p);
    @(posedge i_clock);
    mark_valid <= 1'b0;
  endtask
  task automatic e32(input logic [31:0] w);
    for (int i = 3; i >= 0; i--) exp_q.push_back(w[i*8 +: 8]);
  endtask
  task automatic query(input logic [31:0] start, input logic exact);
    base.reply_q.delete();
    base.send_query(start);
    for (int i = 0; i < 3000 && tx_done !== 1'b1; i++) @(negedge i_clock);
    check(tx_done, 1'b1);
    if (exact) check(base.reply_q.size(), exp_q.size());
    else check(base.reply_q.size() >= exp_q.size(), 1'b1);
    foreach (exp_q[i]) if (i < base.reply_q.size()) check(base.reply_q[i], exp_q[i]);
    exp_q.delete();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    wait_sweep();
    rd_chk(OFF_TOTAL, TOTAL_RESET, 1'b0);
    rd_chk(OFF_CRC, CRC_RESET, 1'b0);
    rd_chk(8'h14, 32'h0000_0000, 1'b1);
    apb(1'b1, OFF_CRC, 32'h1234_5678);
    // upgrade-state reply outside receiving
    for (int s = 0; s < 6; s += 2) begin
      apb(1'b1, OFF_CTRL, 32'(s));
      exp_q = '{8'h50, {4'(s), 4'h0}};
      e32(32'h1234_5678);
      query(32'h0000_0005, 1'b1);
    end
    // ten pages, 3 and 7 missing
    apb(1'b1, OFF_TOTAL, 32'h0000_000A);
    for (int p = 0; p < 10; p++) if (p != 3 && p != 7) mark(p);
    rd_chk(OFF_RCVD, 32'h0000_0008, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h0000_0101);
    exp_q = '{8'h90};
    e32(32'h0000_0008);
    e32(32'h0000_0007);
    e32(32'h0000_0003);
    query(32'h0000_0004, 1'b1);
    slow = 1'b1;
    exp_q = '{8'h90};
    e32(32'h0000_0008);
    e32(32'h0000_0003);
    e32(32'h0000_0007);
    query(32'h0000_0008, 1'b1);
    slow = 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0000_0081);
    exp_q = '{8'h80};
    e32(32'h0000_0008);
    e32(32'h0000_0003);
    exp_q.push_back(8'h88);
    exp_q.push_back(8'h00);
    query(32'h0000_0003, 1'b1);
    // image check busy: empty report
    apb(1'b1, OFF_CTRL, 32'h0000_0091);
    exp_q = '{8'h90};
    e32(32'h0000_0008);
    query(32'h0000_0003, 1'b1);
    // cleared flags, twelve missing, list cut by page size
    apb(1'b1, OFF_CTRL, 32'h0000_0200);
    wait_sweep();
    apb(1'b1, OFF_TOTAL, 32'h0000_000C);
    for (int z = 0; z < 4; z++) begin
      apb(1'b1, OFF_CTRL, 32'h0000_0101 | (z << CTRL_SIZE_LSB));
      exp_q = '{8'h90};
      e32(32'h0000_0000);
      for (int p = 0; p < 12 && p < sizes[z] / 4; p++) e32(32'(p));
      query(32'h0000_0000, 1'b1);
    end
    // auto modes: twelve of twelve missing is dense, bitmap wanted
    for (int m = 0; m < 4; m += 3) begin
      apb(1'b1, OFF_CTRL, 32'h0000_0001 | (m << CTRL_MODE_LSB));
      exp_q = '{8'h80};
      e32(32'h0000_0000);
      e32(32'h0000_0000);
      exp_q.push_back(8'hFF);
      exp_q.push_back(8'hF0);
      query(32'h0000_0000, 1'b1);
    end
    report_and_stop();
  end
endmodule // testbench
